// file: design/lsc_defines.svh
// Register offsets, field positions, reset values and counts of the lockstep self-test block.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LSC_OFF_CTRL     32'hFFFF_E100
`define LSC_OFF_COUNT    32'hFFFF_E104
`define LSC_OFF_DIVIDE_FACTOR_FIELD   32'hFFFF_E108
`define LSC_OFF_TIMEOUT  32'hFFFF_E10C
`define LSC_OFF_STATUS   32'hFFFF_E110
`define LSC_OFF_FAILINT  32'hFFFF_E114
`define LSC_OFF_MASK     32'hFFFF_E118

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LSC_CTRL_START    0
`define LSC_CTRL_RESTART  1
`define LSC_DIV_LSB       0
`define LSC_DIV_MSB       2
`define LSC_ST_PASS       0
`define LSC_ST_SIGFAIL    1
`define LSC_ST_TIMEOUT    2
`define LSC_ST_CMPERR     3
`define LSC_FAIL_NEXT_LSB 8

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define LSC_COUNT_RST     5'h00
`define LSC_DIV_RST       3'h0
`define LSC_TIMEOUT_RST   32'hFFFF_FFFF
`define LSC_MASK_RST      4'h0
`define LSC_INT_CYCLES    11'd1365
`define LSC_NUM_INT       5'd26
`define LSC_CLK_KHZ       10000
`define LSC_TCLK_MAX_KHZ  45000
`define LSC_DIV_MIN       ((`LSC_CLK_KHZ + `LSC_TCLK_MAX_KHZ - 1) / `LSC_TCLK_MAX_KHZ - 1)
`define LSC_LFSR_SEED     32'hACE1_5EED

`endif

// file: design/lsc_pkg.sv
// Types shared by the lockstep self-test modules.
package lsc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CHECK, ST_RESET} lsc_state_t;
	typedef logic [4:0] lsc_int_t;
endpackage : lsc_pkg

// file: design/lsc_cmp_if.sv
// Carrier between the self-test controller and the core compare unit.
interface lsc_cmp_if #(parameter int W = 32);
	logic [W-1:0] core1_sig;
	logic [W-1:0] core2_sig;
	logic         test_active;
	logic         mismatch;
	logic [W-1:0] core1_al;
	logic [W-1:0] core2_al;
	modport ctl (output core1_sig, output core2_sig, output test_active,
		input mismatch, input core1_al, input core2_al);
	modport cmp (input core1_sig, input core2_sig, input test_active,
		output mismatch, output core1_al, output core2_al);
endinterface : lsc_cmp_if

// file: design/lsc_compare.sv
// Core compare unit: aligns the first core to the second and flags mismatches while test_active is low.
module lsc_compare #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	lsc_cmp_if.cmp   bus
);
	import lsc_pkg::*;

	logic [W-1:0] dly1_reg;
	logic [W-1:0] dly2_reg;
	logic         mis_reg;

	// ------------------------------------------------------------------------
	// Delay and compare
	// ------------------------------------------------------------------------
	// The second core runs two cycles behind, so the first core's outputs
	// pass two stages before they meet it; a common fault then hits
	// different instructions in each core.
	wire          differ = (dly2_reg != bus.core2_sig);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dly1_reg <= '0;
			dly2_reg <= '0;
			mis_reg  <= 1'b0;
		end else begin
			dly1_reg <= bus.core1_sig; // RQ2
			dly2_reg <= dly1_reg; // RQ2
			mis_reg  <= differ && !bus.test_active; // RQ1
		end
	end

	assign bus.core1_al = dly2_reg;
	assign bus.core2_al = bus.core2_sig;
	assign bus.mismatch = mis_reg;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	chk_align_two_cycles: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
		##2 bus.core1_al == $past(bus.core1_sig, 2))
		else $error("first core not delayed by two cycles");

	chk_mismatch_flagged: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
		(!bus.test_active && $past(bus.core1_sig, 2) != bus.core2_sig) ##0 $past(rst_b, 2)
		|=> bus.mismatch)
		else $error("core output mismatch not flagged");
endmodule : lsc_compare

// file: design/lsc_self_test.sv
// Lockstep self-test controller with register port and core compare unit.
// Behaviour
// RQ1: Compare first core outputs against second core every cycle; flag mismatches. No flag is raised while test_active is high, during a run.
// RQ2: First core outputs delayed two cycles to align with second core.
// RQ3: Software initialises core registers on both cores before use.
// RQ4: Built-in logic test drives patterns into cores and compresses responses.
// RQ5: Runs split into numbered intervals; run all or a chosen count.
// RQ6: New run resumes after last interval or restarts at first.
// RQ7: Core under test isolated from system while a run is active.
// RQ8: Failing interval number captured and held for software.
// RQ9: Timeout counter loaded per run; expiry ends run as failed.
// RQ10: Test clock divided from processor clock, never above its maximum rate.
// RQ11: Divide factor field divides the clock by one to eight.
// RQ12: Each interval takes a fixed count of test clocks; 26 intervals.
// RQ13: Software sets clocks, count, timeout, saves state, then starts.
// RQ14: Finished run resets the processor; software then reads status.
// RQ15: Status tells pass, signature fail, timeout apart; held until cleared.
//
// The plain strobed port is this design's own decision.
`include "lsc_defines.svh"

module lsc_self_test #(
	parameter int SIG_W = 32
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [31:0]       addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	input  wire logic [SIG_W-1:0]  core1_out,
	input  wire logic [SIG_W-1:0]  core2_out,
	output logic [31:0]            rdata,
	output logic                   irq,
	output logic                   core_isolate,
	output logic                   core_reset,
	output logic [SIG_W-1:0]       bist_pattern,
	output lsc_pkg::lsc_int_t      active_interval
);
	import lsc_pkg::*;

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	function automatic logic [SIG_W-1:0] lfsr_step(input logic [SIG_W-1:0] s);
		lfsr_step = {s[SIG_W-2:0], s[SIG_W-1] ^ s[SIG_W-2] ^ s[0]};
	endfunction : lfsr_step

	function automatic logic [SIG_W-1:0] misr_step(input logic [SIG_W-1:0] s,
		input logic [SIG_W-1:0] d);
		misr_step = lfsr_step(s) ^ d;
	endfunction : misr_step

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	lsc_state_t       state_reg;
	lsc_state_t       state_next;
	logic [4:0]       count_reg;
	logic [2:0]       div_reg;
	logic [31:0]      timeout_reg;
	logic [3:0]       status_reg;
	logic [3:0]       status_next;
	logic [3:0]       mask_reg;
	lsc_int_t         fail_int_reg;
	lsc_int_t         next_int_reg;
	lsc_int_t         cur_int_reg;
	lsc_int_t         done_reg;
	logic [2:0]       div_cnt_reg;
	logic             test_en_reg;
	logic [10:0]      cyc_reg;
	logic [31:0]      tmo_cnt_reg;
	logic [SIG_W-1:0] lfsr_reg;
	logic [SIG_W-1:0] misr1_reg;
	logic [SIG_W-1:0] misr2_reg;
	logic [31:0]      rdata_reg;
	logic             irq_reg;
	logic             iso_reg;
	logic             rst_out_reg;

	lsc_cmp_if #(.W(SIG_W)) cmp_bus();

	lsc_compare #(.W(SIG_W)) u_compare (
		.clk   (clk),
		.rst_b (rst_b),
		.bus   (cmp_bus.cmp)
	);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	wire idle      = (state_reg == ST_IDLE);
	wire running   = (state_reg == ST_RUN);
	wire checking  = (state_reg == ST_CHECK);
	wire wr_ctrl   = wr && (addr == `LSC_OFF_CTRL);
	wire wr_count  = wr && (addr == `LSC_OFF_COUNT) && idle;
	wire wr_div    = wr && (addr == `LSC_OFF_DIVIDE_FACTOR_FIELD) && idle;
	wire wr_tmo    = wr && (addr == `LSC_OFF_TIMEOUT) && idle;
	wire wr_status = wr && (addr == `LSC_OFF_STATUS);
	wire wr_mask   = wr && (addr == `LSC_OFF_MASK);
	wire start     = wr_ctrl && wdata[`LSC_CTRL_START] && idle;
	wire restart   = wdata[`LSC_CTRL_RESTART];

	// A setting below the minimum is raised so the test clock stays legal.
	wire [2:0] div_min = 3'(`LSC_DIV_MIN);
	wire [2:0] div_eff = (div_reg < div_min) ? div_min : div_reg; // RQ10
	wire [4:0] run_len = (count_reg == 5'h00 || count_reg > `LSC_NUM_INT) ?
		`LSC_NUM_INT : count_reg; // RQ5
	wire       int_end  = running && test_en_reg && (cyc_reg == `LSC_INT_CYCLES - 11'd1);
	wire       tmo_hit  = running && (tmo_cnt_reg == 32'h0000_0000);
	wire       sig_bad  = (misr1_reg != misr2_reg);
	wire       last_int = (done_reg + 5'd1 == run_len) ||
		(cur_int_reg == `LSC_NUM_INT - 5'd1);
	wire       div_hit  = (div_cnt_reg == div_eff);
	wire [SIG_W-1:0] int_seed = SIG_W'(`LSC_LFSR_SEED) ^ SIG_W'(cur_int_reg);
	wire [SIG_W-1:0] run_seed = SIG_W'(`LSC_LFSR_SEED) ^
		SIG_W'(restart ? 5'h00 : next_int_reg);

	wire [3:0] status_set = {cmp_bus.mismatch, tmo_hit, checking && sig_bad,
		checking && !sig_bad && last_int};
	wire [3:0] status_clr = wr_status ? wdata[3:0] : 4'h0;

	assign cmp_bus.core1_sig   = core1_out;
	assign cmp_bus.core2_sig   = core2_out;
	assign cmp_bus.test_active = iso_reg;

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:  if (start) state_next = ST_RUN;
			ST_RUN: begin
				if (tmo_hit) state_next = ST_RESET; // RQ9
				else if (int_end) state_next = ST_CHECK;
			end
			ST_CHECK: state_next = (sig_bad || last_int) ? ST_RESET : ST_RUN;
			ST_RESET: state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end

	// A set that lands in the same cycle as its clear is kept.
	assign status_next = (status_reg & ~status_clr) | status_set; // RQ15

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= ST_IDLE;
			status_reg  <= 4'h0;
			irq_reg     <= 1'b0;
			iso_reg     <= 1'b0;
			rst_out_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			status_reg  <= status_next;
			irq_reg     <= |(status_next & mask_reg);
			iso_reg     <= (state_next == ST_RUN) || (state_next == ST_CHECK); // RQ7
			rst_out_reg <= (state_next == ST_RESET); // RQ14
		end
	end

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg   <= `LSC_COUNT_RST;
			div_reg     <= `LSC_DIV_RST;
			timeout_reg <= `LSC_TIMEOUT_RST;
			mask_reg    <= `LSC_MASK_RST;
		end else begin
			if (wr_count) count_reg <= wdata[4:0];
			if (wr_div) div_reg <= wdata[`LSC_DIV_MSB:`LSC_DIV_LSB]; // RQ11
			if (wr_tmo) timeout_reg <= wdata;
			if (wr_mask) mask_reg <= wdata[3:0];
		end
	end

	// ------------------------------------------------------------------------
	// Interval bookkeeping
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_int_reg  <= 5'h00;
			next_int_reg <= 5'h00;
			done_reg     <= 5'h00;
			fail_int_reg <= 5'h00;
		end else if (start) begin
			cur_int_reg <= restart ? 5'h00 : next_int_reg; // RQ6
			done_reg    <= 5'h00;
		end else if (checking && sig_bad) begin
			fail_int_reg <= cur_int_reg; // RQ8
		end else if (tmo_hit) begin
			fail_int_reg <= cur_int_reg;
		end else if (checking) begin
			cur_int_reg  <= cur_int_reg + 5'd1;
			done_reg     <= done_reg + 5'd1; // RQ5
			next_int_reg <= (cur_int_reg == `LSC_NUM_INT - 5'd1) ? 5'h00 :
				cur_int_reg + 5'd1; // RQ6
		end
	end

	// ------------------------------------------------------------------------
	// Test clock, timeout and logic test engine
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_reg <= 3'h0;
			test_en_reg <= 1'b0;
		end else if (running && !int_end) begin
			div_cnt_reg <= div_hit ? 3'h0 : div_cnt_reg + 3'd1; // RQ11
			test_en_reg <= div_hit; // RQ10
		end else begin
			div_cnt_reg <= 3'h0;
			test_en_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_reg     <= 11'd0;
			tmo_cnt_reg <= 32'h0000_0000;
		end else begin
			if (start || checking) cyc_reg <= 11'd0;
			else if (running && test_en_reg) cyc_reg <= cyc_reg + 11'd1; // RQ12
			if (start) tmo_cnt_reg <= timeout_reg; // RQ9
			else if (running && !tmo_hit) tmo_cnt_reg <= tmo_cnt_reg - 32'd1;
		end
	end

	// Both cores see the same pattern; their compressed responses must agree,
	// so no table of golden signatures is needed.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr_reg  <= '0;
			misr1_reg <= '0;
			misr2_reg <= '0;
		end else if (start) begin
			lfsr_reg  <= run_seed;
			misr1_reg <= '0;
			misr2_reg <= '0;
		end else if (checking) begin
			lfsr_reg  <= lfsr_step(int_seed ^ SIG_W'(1));
			misr1_reg <= '0;
			misr2_reg <= '0;
		end else if (running && test_en_reg) begin
			lfsr_reg  <= lfsr_step(lfsr_reg); // RQ4
			misr1_reg <= misr_step(misr1_reg, cmp_bus.core1_al); // RQ4
			misr2_reg <= misr_step(misr2_reg, cmp_bus.core2_al);
		end
	end

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------
	wire [31:0] rd_mux =
		(addr == `LSC_OFF_CTRL)    ? {31'h0, iso_reg} :
		(addr == `LSC_OFF_COUNT)   ? {27'h0, count_reg} :
		(addr == `LSC_OFF_DIVIDE_FACTOR_FIELD)  ? {29'h0, div_reg} :
		(addr == `LSC_OFF_TIMEOUT) ? timeout_reg :
		(addr == `LSC_OFF_STATUS)  ? {28'h0, status_reg} :
		(addr == `LSC_OFF_FAILINT) ? {19'h0, next_int_reg, 3'h0, fail_int_reg} :
		(addr == `LSC_OFF_MASK)    ? {28'h0, mask_reg} : 32'h0000_0000;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) rdata_reg <= 32'h0000_0000;
		else rdata_reg <= rd ? rd_mux : 32'h0000_0000;
	end

	assign rdata           = rdata_reg;
	assign irq             = irq_reg;
	assign core_isolate    = iso_reg;
	assign core_reset      = rst_out_reg;
	assign bist_pattern    = lfsr_reg;
	assign active_interval = cur_int_reg;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_run_start;
		idle && start;
	endsequence

	sequence s_run_end;
		state_reg == ST_RESET && core_reset;
	endsequence

	chk_start_isolates: assert property (s_run_start |=> core_isolate && running) // RQ7
		else $error("core not isolated at run start");
	chk_timeout_ends: assert property (tmo_hit |=> s_run_end ##1 !core_isolate) // RQ9
		else $error("timeout did not end the run");
	chk_timeout_status: assert property (tmo_hit |=> status_reg[`LSC_ST_TIMEOUT]) // RQ15
		else $error("timeout not recorded");
	chk_fail_captured: assert property (checking && sig_bad |=> // RQ8
		fail_int_reg == $past(cur_int_reg) && status_reg[`LSC_ST_SIGFAIL])
		else $error("failing interval not captured");
	chk_resume_point: assert property (s_run_start ##0 !restart |=> // RQ6
		cur_int_reg == $past(next_int_reg))
		else $error("run did not resume after last interval");
	chk_restart_point: assert property (s_run_start ##0 restart |=> cur_int_reg == 5'h00) // RQ6
		else $error("restart did not begin at first interval");
	chk_interval_len: assert property (running |-> cyc_reg < `LSC_INT_CYCLES) // RQ12
		else $error("interval exceeded its cycle count");
	chk_div_spacing: assert property (test_en_reg && div_eff == 3'h1 && running // RQ11
		|=> !test_en_reg)
		else $error("test clock faster than divide factor");
	chk_pattern_moves: assert property (running && test_en_reg |=> // RQ4
		lfsr_reg != $past(lfsr_reg) || !running)
		else $error("pattern generator stalled");
	chk_count_limit: assert property (checking |-> done_reg < run_len) // RQ5
		else $error("more intervals than selected");
	chk_pass_held: assert property (status_reg[`LSC_ST_PASS] && !(wr_status && // RQ15
		wdata[`LSC_ST_PASS]) |=> status_reg[`LSC_ST_PASS])
		else $error("pass status lost without clear");
	chk_reset_pulse: assert property (core_reset |=> !core_reset && idle) // RQ14
		else $error("processor reset not a single pulse");
endmodule : lsc_self_test

// file: verif/lsc_core_pair.sv
// Behavioural model of the two lockstep cores that face the self-test block.
module lsc_core_pair #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         core_isolate,
	input  wire logic [W-1:0] bist_pattern,
	input  wire logic         fault,
	output logic [W-1:0]      core1_out,
	output logic [W-1:0]      core2_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [W-1:0] cnt_reg;
	logic [W-1:0] dly1_reg;
	logic [W-1:0] dly2_reg;

	// ------------------------------------------------------------------------
	// Core state
	// ------------------------------------------------------------------------
	// Every core register starts from a defined value, so stale content never trips the compare.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg  <= '0;
			dly1_reg <= '0;
			dly2_reg <= '0;
		end else begin
			cnt_reg  <= cnt_reg + W'(1);
			dly1_reg <= core1_out;
			dly2_reg <= dly1_reg;
		end
	end

	// While isolated the cores mix the test pattern into the outputs of their running code.
	assign core1_out = cnt_reg ^ (core_isolate ? bist_pattern : '0);
	// The second core trails by two cycles; a fault flips all its outputs.
	assign core2_out = dly2_reg ^ {W{fault}};

endmodule : lsc_core_pair

// file: verif/lsc_self_test_tb.sv
// Self-checking testbench of the lockstep self-test block.
`include "lsc_defines.svh"

module lsc_self_test_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                 clk;
	logic                 rst_b;
	logic                 wr;
	logic                 rd;
	logic                 fault;
	logic [31:0]          addr;
	logic [31:0]          wdata;
	logic [31:0]          rdata;
	logic                 irq;
	logic                 core_isolate;
	logic                 core_reset;
	logic [31:0]          core1_out;
	logic [31:0]          core2_out;
	logic [31:0]          bist_pattern;
	lsc_pkg::lsc_int_t    active_interval;
	logic [31:0]          v;
	int                   bad_count;
	int                   cmp_count;

	// ------------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------------
	lsc_self_test #(.SIG_W(32)) u_dut (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.core1_out(core1_out), .core2_out(core2_out), .rdata(rdata), .irq(irq),
		.core_isolate(core_isolate), .core_reset(core_reset),
		.bist_pattern(bist_pattern), .active_interval(active_interval)
	);

	lsc_core_pair #(.W(32)) u_cores (
		.clk(clk), .rst_b(rst_b), .core_isolate(core_isolate),
		.bist_pattern(bist_pattern), .fault(fault),
		.core1_out(core1_out), .core2_out(core2_out)
	);

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask : rd_chk

	// Configures and starts one run, then follows it to the processor reset.
	task automatic run_test(input logic [4:0] n, input logic [2:0] d, input logic [31:0] tmo,
		input logic rs, input logic flt, input logic pk, input logic [4:0] start,
		input logic [31:0] st_exp, output logic [31:0] fi);
		int nn;
		int lo;
		int hi;
		int cyc;
		nn = (n == 5'h0) ? 26 : int'(n);
		// Each interval adds its check cycle and one cycle to restart the divider.
		hi = nn * (`LSC_INT_CYCLES * (d + 1) + 2) + 6;
		lo = (st_exp != 32'h1) ? 0 : nn * `LSC_INT_CYCLES * (d + 1) - 6;
		if (tmo < 32'h3E8) begin
			lo = int'(tmo) - 6;
			hi = int'(tmo) + 6;
		end
		wr_reg(`LSC_OFF_DIVIDE_FACTOR_FIELD, {29'h0, d});
		wr_reg(`LSC_OFF_COUNT, {27'h0, n});
		wr_reg(`LSC_OFF_TIMEOUT, tmo);
		wr_reg(`LSC_OFF_CTRL, {30'h0, rs, 1'h1});
		// The fault is raised only once the cores are isolated, so it never trips the compare.
		fault <= flt;
		#1;
		chk({31'h0, core_isolate}, 32'h1);
		chk({27'h0, active_interval}, {27'h0, start});
		chk(bist_pattern, `LSC_LFSR_SEED ^ {27'h0, start});
		if (pk) begin
			wr_reg(`LSC_OFF_COUNT, 32'h9);
		end
		for (cyc = 0; cyc < hi && core_reset !== 1'h1; cyc++) begin
			@(posedge clk);
			#1;
			if (core_reset !== 1'h1) begin
				chk({31'h0, core_isolate}, 32'h1);
			end
		end
		chk({31'h0, core_reset}, 32'h1);
		if (core_reset !== 1'h1) begin
			final_report;
		end
		chk({31'h0, core_isolate}, 32'h0);
		chk({31'h0, cyc >= lo}, 32'h1);
		fault <= 1'h0;
		repeat (3) @(posedge clk);
		rd_reg(`LSC_OFF_STATUS, v);
		chk(v, st_exp);
		rd_reg(`LSC_OFF_FAILINT, fi);
		wr_reg(`LSC_OFF_STATUS, 32'hF);
		rd_chk(`LSC_OFF_STATUS, 32'h0);
	endtask : run_test

	// ------------------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	initial begin
		logic [31:0] fi;
		rst_b     = 1'h0;
		wr        = 1'h0;
		rd        = 1'h0;
		fault     = 1'h0;
		addr      = 32'h0;
		wdata     = 32'h0;
		bad_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		rd_chk(`LSC_OFF_COUNT, 32'h0);
		rd_chk(`LSC_OFF_DIVIDE_FACTOR_FIELD, 32'h0);
		rd_chk(`LSC_OFF_TIMEOUT, 32'hFFFF_FFFF);
		rd_chk(`LSC_OFF_MASK, 32'h0);
		rd_chk(`LSC_OFF_STATUS, 32'h0);
		rd_chk(`LSC_OFF_FAILINT, 32'h0);
		rd_chk(32'hFFFF_E11C, 32'h0);
		$display("test reset values done");

		// A one-cycle fault on the trailing core must raise a masked-off compare error.
		@(posedge clk);
		fault <= 1'h1;
		@(posedge clk);
		fault <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		rd_chk(`LSC_OFF_STATUS, 32'h8);
		wr_reg(`LSC_OFF_MASK, 32'h8);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr_reg(`LSC_OFF_STATUS, 32'h8);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		rd_chk(`LSC_OFF_STATUS, 32'h0);
		$display("test compare error done");

		run_test(5'h1, 3'h0, 32'hFFFF_FFFF, 1'h1, 1'h0, 1'h0, 5'h0, 32'h1, fi);
		chk({27'h0, fi[12:8]}, 32'h1);
		$display("test single interval done");

		run_test(5'h1, 3'h1, 32'hFFFF_FFFF, 1'h0, 1'h0, 1'h1, 5'h1, 32'h1, fi);
		chk({27'h0, fi[12:8]}, 32'h2);
		rd_chk(`LSC_OFF_COUNT, 32'h1);
		$display("test resume and divider done");

		run_test(5'h1, 3'h0, 32'h32, 1'h1, 1'h0, 1'h0, 5'h0, 32'h4, fi);
		$display("test timeout done");

		run_test(5'h3, 3'h0, 32'hFFFF_FFFF, 1'h0, 1'h1, 1'h0, 5'h2, 32'h2, fi);
		chk({27'h0, fi[4:0]}, 32'h2);
		$display("test signature failure done");

		run_test(5'h0, 3'h0, 32'hFFFF_FFFF, 1'h1, 1'h0, 1'h0, 5'h0, 32'h1, fi);
		chk({27'h0, fi[12:8]}, 32'h0);
		$display("test full run done");
		final_report;
	end

endmodule : lsc_self_test_tb
